// [src/ppml_pkg.sv]
// per-port phy register bank: offsets, fields, reset values and types
// assumes a 40 MHz core clock and an apb master with 32-bit data
package ppml_pkg;

  // register indices; byte address on apb is four times the index
  localparam logic [15:0] IDX_NP_ABILITY = 16'h0110;
  localparam logic [15:0] IDX_MMD_SETUP = 16'h011a;
  localparam logic [15:0] IDX_MMD_DATA = 16'h011c;
  localparam logic [15:0] IDX_LOOPBACK = 16'h0122;
  localparam logic [15:0] IDX_LINK_STAT = 16'h0126;
  localparam logic [15:0] IDX_SYMERR_CNT = 16'h012a;
  localparam logic [15:0] IDX_IRQ_STAT = 16'h0140;
  localparam logic [15:0] IDX_IRQ_CLR = 16'h0142;
  localparam logic [15:0] IDX_IRQ_EN = 16'h0144;
  localparam int ADDR_W = 12;

  // field positions
  localparam int NP_MORE_BIT = 15;
  localparam int NP_ACK_BIT = 14;
  localparam int NP_MSGPG_BIT = 13;
  localparam int NP_ACK2_BIT = 12;
  localparam int NP_TOGGLE_BIT = 11;
  localparam int MODE_LSB = 14;
  localparam int DEV_W = 5;
  localparam int LOOP_EN_BIT = 8;
  localparam int LOOP_RC_BIT = 1;
  localparam int LOOP_RO_BIT = 0;
  localparam int LINK_UP_BIT = 0;

  // reset values
  localparam logic [15:0] SETUP_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] LOOP_RST = 16'h00f4;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] NP_RST = 16'h0000;
  localparam logic [15:0] PTR_RST = 16'h0000;

  // interrupt status bits
  localparam int IRQ_PAGE = 0;
  localparam int IRQ_SYMERR = 1;
  localparam int IRQ_LINK_UP = 2;
  localparam int IRQ_LINK_DOWN = 3;
  localparam int IRQ_W = 4;

  typedef enum logic [1:0] {
    MODE_PTR = 2'b00,
    MODE_DATA = 2'b01,
    MODE_INC_RW = 2'b10,
    MODE_INC_WR = 2'b11
  } ppml_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CAPT = 3'b010,
    ST_DONE = 3'b100
  } ppml_state_e;

  // next page word as received from the partner
  typedef struct packed {
    logic more_pages;
    logic ack;
    logic msg_page;
    logic ack2;
    logic prev_toggle;
    logic [10:0] message;
  } ppml_np_word_s;

  // one nibble of line data
  typedef struct packed {
    logic valid;
    logic [3:0] data;
  } ppml_nibble_s;

endpackage

// [src/ppml_mmd_bank.sv]
// mmd storage: one address pointer per device and the register words
// assumes one access per cycle from the register slave
`timescale 1ns/1ps
module ppml_mmd_bank #(
  parameter int REG_AW = 4
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // access
  input wire logic [ppml_pkg::DEV_W-1:0] i_dev,
  input wire logic i_ptr_wr,
  input wire logic i_data_wr,
  input wire logic i_inc,
  input wire logic [15:0] i_wdata,
  // read back
  output logic [15:0] o_ptr,
  output logic [15:0] o_data
);
  localparam int DEV_N = 2 ** ppml_pkg::DEV_W;
  localparam int REG_N = 2 ** REG_AW;

  generate
    if (REG_AW < 1 || REG_AW > 8) begin : g_chk
      $error("ppml_mmd_bank: REG_AW must be 1..8");
    end
  endgenerate

  logic [15:0] ptr_r [DEV_N];
  logic [15:0] ptr_nxt [DEV_N];
  logic [15:0] mem_r [DEV_N*REG_N];
  logic [15:0] mem_nxt [DEV_N*REG_N];
  logic [REG_AW-1:0] slot;

  // pointer bits above REG_AW alias onto the stored words
  assign slot = ptr_r[i_dev][REG_AW-1:0];
  assign o_ptr = ptr_r[i_dev];
  assign o_data = mem_r[{i_dev, slot}];

  always_comb begin
    ptr_nxt = ptr_r;
    mem_nxt = mem_r;
    if (i_ptr_wr) begin
      ptr_nxt[i_dev] = i_wdata; // RULE_08
    end
    if (i_data_wr) begin
      mem_nxt[{i_dev, slot}] = i_wdata; // RULE_09
    end
    if (i_inc) begin
      ptr_nxt[i_dev] = ptr_r[i_dev] + 16'h0001; // RULE_12
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      for (int d = 0; d < DEV_N; d++) begin
        ptr_r[d] <= ppml_pkg::PTR_RST;
      end
      for (int m = 0; m < DEV_N*REG_N; m++) begin
        mem_r[m] <= ppml_pkg::DATA_RST;
      end
    end else begin
      ptr_r <= ptr_nxt;
      mem_r <= mem_nxt;
    end
  end
endmodule

// [src/ppml_regs.sv]
// per-port phy register bank behind an apb slave
// assumes link-side inputs synchronous to i_core_clk, apb from one master
`timescale 1ns/1ps

// What this block does
// RULE_01: bit 15 shows partner has more pages
// RULE_02: bits 14..12 show partner page flags
// RULE_03: bit 11 inverted previous toggle, message below
// RULE_04: mode field resets 00; 10 increments always
// RULE_05: mode 01 data access, no increment
// RULE_06: mode 11 increments after writes only
// RULE_07: setup bits 4:0 select mmd device
// RULE_08: mode 00 data register is address pointer
// RULE_09: nonzero mode data register is register content
// RULE_10: loopback bit returns receive data to transmit
// RULE_11: count errored frames, clear when read
// RULE_12: link status bit; increment step is one
module ppml_regs #(
  parameter int REG_AW = 4
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ppml_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // link side
  input wire logic i_np_valid,
  input wire ppml_pkg::ppml_np_word_s i_np_word,
  input wire logic i_link_up,
  input wire logic i_receive_symbol_error,
  input wire logic i_rx_frame_end,
  input wire ppml_pkg::ppml_nibble_s i_rx_nibble,
  input wire ppml_pkg::ppml_nibble_s i_fabric_nibble,
  output ppml_pkg::ppml_nibble_s o_tx_nibble,
  output logic o_remote_loopback,
  // interrupt
  output logic o_irq
);
  // slot index width and the word index padding both rely on these bounds
  generate
    if (REG_AW < 1 || REG_AW > 8) begin : g_chk_aw
      $error("ppml_regs: REG_AW must be 1..8");
    end
    if (ppml_pkg::ADDR_W != 12) begin : g_chk_addr
      $error("ppml_regs: word index padding assumes 12 address bits");
    end
  endgenerate

  ppml_pkg::ppml_state_e state_r, state_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [15:0] np_r, np_nxt;
  logic [15:0] setup_r, setup_nxt;
  logic [15:0] loop_r, loop_nxt;
  logic link_r, link_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic frame_err_r, frame_err_nxt;
  logic [ppml_pkg::IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
  logic [ppml_pkg::IRQ_W-1:0] irq_en_r, irq_en_nxt;
  logic irq_r, irq_nxt;
  ppml_pkg::ppml_nibble_s tx_r, tx_nxt;

  logic [15:0] idx;
  logic capt, done, wr_done, rd_capt, hit;
  logic [15:0] wdata;
  logic [ppml_pkg::IRQ_W-1:0] ev;
  logic frame_bad;
  ppml_pkg::ppml_mode_e mode;
  logic mmd_ptr_wr, mmd_data_wr, mmd_inc;
  logic [15:0] mmd_ptr, mmd_data;

  // byte address bits 1:0 are ignored; word index is the register index
  assign idx = {6'h00, i_paddr[ppml_pkg::ADDR_W-1:2]};
  assign wdata = i_pwdata[15:0];
  assign capt = (state_r == ppml_pkg::ST_CAPT);
  assign done = (state_r == ppml_pkg::ST_DONE) && i_psel && i_penable;
  assign wr_done = done && i_pwrite && !pslverr_r;
  assign rd_capt = capt && !i_pwrite;
  assign mode = ppml_pkg::ppml_mode_e'(setup_r[15:ppml_pkg::MODE_LSB]);

  // unmapped indices answer with pslverr and drop writes
  always_comb begin
    case (idx)
      ppml_pkg::IDX_NP_ABILITY, ppml_pkg::IDX_MMD_SETUP,
      ppml_pkg::IDX_MMD_DATA, ppml_pkg::IDX_LOOPBACK,
      ppml_pkg::IDX_LINK_STAT, ppml_pkg::IDX_SYMERR_CNT,
      ppml_pkg::IDX_IRQ_STAT, ppml_pkg::IDX_IRQ_CLR,
      ppml_pkg::IDX_IRQ_EN: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // mmd data register access; a mode 10 read increments when its value is captured
  always_comb begin
    mmd_ptr_wr = 1'b0;
    mmd_data_wr = 1'b0;
    mmd_inc = 1'b0;
    if (idx == ppml_pkg::IDX_MMD_DATA) begin
      if (mode == ppml_pkg::MODE_PTR) begin
        mmd_ptr_wr = wr_done; // RULE_08
      end else begin
        mmd_data_wr = wr_done; // RULE_09
      end
      case (mode)
        ppml_pkg::MODE_PTR: mmd_inc = 1'b0;
        ppml_pkg::MODE_DATA: mmd_inc = 1'b0; // RULE_05
        ppml_pkg::MODE_INC_RW: mmd_inc = wr_done || rd_capt; // RULE_04
        ppml_pkg::MODE_INC_WR: mmd_inc = wr_done; // RULE_06
        default: mmd_inc = 1'b0;
      endcase
    end
  end

  ppml_mmd_bank #(
    .REG_AW(REG_AW)
  ) u_bank (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_dev(setup_r[ppml_pkg::DEV_W-1:0]), // RULE_07
    .i_ptr_wr(mmd_ptr_wr),
    .i_data_wr(mmd_data_wr),
    .i_inc(mmd_inc),
    .i_wdata(wdata),
    .o_ptr(mmd_ptr),
    .o_data(mmd_data)
  );

  // a frame counts once however many symbol errors it holds
  assign frame_bad = i_rx_frame_end &&
                     (frame_err_r || i_receive_symbol_error);
  always_comb begin
    ev = '0;
    ev[ppml_pkg::IRQ_PAGE] = i_np_valid;
    ev[ppml_pkg::IRQ_SYMERR] = frame_bad;
    ev[ppml_pkg::IRQ_LINK_UP] = i_link_up && !link_r;
    ev[ppml_pkg::IRQ_LINK_DOWN] = !i_link_up && link_r;
  end

  // apb handshake: setup, one capture cycle, then pready
  always_comb begin
    state_nxt = state_r;
    pready_nxt = 1'b0;
    pslverr_nxt = pslverr_r;
    prdata_nxt = prdata_r;
    case (state_r)
      ppml_pkg::ST_IDLE: begin
        if (i_psel && i_penable) begin
          state_nxt = ppml_pkg::ST_CAPT;
        end
      end
      ppml_pkg::ST_CAPT: begin
        state_nxt = ppml_pkg::ST_DONE;
        pready_nxt = 1'b1;
        pslverr_nxt = !hit;
        prdata_nxt = 32'h0000_0000;
        if (!i_pwrite) begin
          case (idx)
            ppml_pkg::IDX_NP_ABILITY: prdata_nxt[15:0] = np_r;
            ppml_pkg::IDX_MMD_SETUP: prdata_nxt[15:0] = setup_r;
            ppml_pkg::IDX_MMD_DATA: begin
              if (mode == ppml_pkg::MODE_PTR) begin
                prdata_nxt[15:0] = mmd_ptr; // RULE_08
              end else begin
                prdata_nxt[15:0] = mmd_data; // RULE_09
              end
            end
            ppml_pkg::IDX_LOOPBACK: prdata_nxt[15:0] = loop_r;
            ppml_pkg::IDX_LINK_STAT:
              prdata_nxt[ppml_pkg::LINK_UP_BIT] = link_r; // RULE_12
            ppml_pkg::IDX_SYMERR_CNT: prdata_nxt[15:0] = cnt_r;
            ppml_pkg::IDX_IRQ_STAT:
              prdata_nxt[ppml_pkg::IRQ_W-1:0] = irq_stat_r;
            ppml_pkg::IDX_IRQ_EN:
              prdata_nxt[ppml_pkg::IRQ_W-1:0] = irq_en_r;
            default: prdata_nxt = 32'h0000_0000;
          endcase
        end
      end
      ppml_pkg::ST_DONE: begin
        state_nxt = ppml_pkg::ST_IDLE;
        pslverr_nxt = 1'b0;
      end
      default: state_nxt = ppml_pkg::ST_IDLE;
    endcase
  end

  // register contents, link tracking and interrupt
  always_comb begin
    np_nxt = np_r;
    setup_nxt = setup_r;
    loop_nxt = loop_r;
    // link status shows the link input one clock late
    link_nxt = i_link_up; // RULE_12
    cnt_nxt = cnt_r;
    frame_err_nxt = frame_err_r;
    irq_en_nxt = irq_en_r;
    irq_stat_nxt = irq_stat_r;
    if (i_np_valid) begin
      np_nxt[ppml_pkg::NP_MORE_BIT] = i_np_word.more_pages; // RULE_01
      np_nxt[ppml_pkg::NP_ACK_BIT] = i_np_word.ack; // RULE_02
      np_nxt[ppml_pkg::NP_MSGPG_BIT] = i_np_word.msg_page; // RULE_02
      np_nxt[ppml_pkg::NP_ACK2_BIT] = i_np_word.ack2; // RULE_02
      np_nxt[ppml_pkg::NP_TOGGLE_BIT] = !i_np_word.prev_toggle; // RULE_03
      np_nxt[10:0] = i_np_word.message; // RULE_03
    end
    // clear on read happens at capture, so a frame ending then still counts
    if (rd_capt && idx == ppml_pkg::IDX_SYMERR_CNT) begin
      cnt_nxt = ppml_pkg::CNT_RST; // RULE_11
    end
    if (rd_capt && idx == ppml_pkg::IDX_LOOPBACK) begin
      loop_nxt[ppml_pkg::LOOP_RC_BIT] = 1'b0;
    end
    if (frame_bad && cnt_nxt != ppml_pkg::CNT_MAX) begin
      cnt_nxt = cnt_nxt + 16'h0001; // RULE_11
    end
    if (i_rx_frame_end) begin
      frame_err_nxt = 1'b0;
    end else if (i_receive_symbol_error) begin
      frame_err_nxt = 1'b1;
    end
    if (wr_done) begin
      case (idx)
        ppml_pkg::IDX_MMD_SETUP: setup_nxt = wdata; // RULE_04
        ppml_pkg::IDX_LOOPBACK: begin
          loop_nxt = wdata; // RULE_10
          loop_nxt[ppml_pkg::LOOP_RO_BIT] = 1'b0;
        end
        ppml_pkg::IDX_IRQ_CLR:
          irq_stat_nxt = irq_stat_r & ~wdata[ppml_pkg::IRQ_W-1:0];
        ppml_pkg::IDX_IRQ_EN: irq_en_nxt = wdata[ppml_pkg::IRQ_W-1:0];
        default: irq_en_nxt = irq_en_r;
      endcase
    end
    // a new event wins over a clear in the same cycle
    irq_stat_nxt = irq_stat_nxt | ev;
    // built from next values, so the output never lags the status
    irq_nxt = |(irq_stat_nxt & irq_en_nxt);
  end

  // loopback bypasses the fabric; one register stage either way
  always_comb begin
    if (loop_r[ppml_pkg::LOOP_EN_BIT]) begin
      tx_nxt = i_rx_nibble; // RULE_10
    end else begin
      tx_nxt = i_fabric_nibble;
    end
  end

  // bus handshake group
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_r <= ppml_pkg::ST_IDLE;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // register contents, link side and interrupt group
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      np_r <= ppml_pkg::NP_RST;
      setup_r <= ppml_pkg::SETUP_RST;
      loop_r <= ppml_pkg::LOOP_RST;
      link_r <= 1'b0;
      cnt_r <= ppml_pkg::CNT_RST;
      frame_err_r <= 1'b0;
      irq_stat_r <= '0;
      irq_en_r <= '0;
      irq_r <= 1'b0;
      tx_r <= '0;
    end else begin
      np_r <= np_nxt;
      setup_r <= setup_nxt;
      loop_r <= loop_nxt;
      link_r <= link_nxt;
      cnt_r <= cnt_nxt;
      frame_err_r <= frame_err_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_en_r <= irq_en_nxt;
      irq_r <= irq_nxt;
      tx_r <= tx_nxt;
    end
  end

  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_irq = irq_r;
  assign o_tx_nibble = tx_r;
  assign o_remote_loopback = loop_r[ppml_pkg::LOOP_EN_BIT];
endmodule

// [verif/ppml_regs_checker.sv]
// assertions on the apb handshake and the loopback path of ppml_regs
// assumes the bind below and a single clock domain
`timescale 1ns/1ps
module ppml_regs_checker (
  // watched ports
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ppml_pkg::ADDR_W-1:0] i_paddr,
  input wire ppml_pkg::ppml_nibble_s i_rx_nibble,
  input wire ppml_pkg::ppml_nibble_s i_fabric_nibble,
  input wire ppml_pkg::ppml_nibble_s o_tx_nibble,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_remote_loopback,
  input wire logic o_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  logic wr_lb;
  assign wr_lb = o_pready && i_pwrite && i_paddr == 12'h488;
  AST_TX_LOOP: assert property (
    !$past(i_sys_rst) && $past(o_remote_loopback)
    |-> o_tx_nibble == $past(i_rx_nibble)) else $error("loop data wrong");
  AST_TX_FAB: assert property (
    !$past(i_sys_rst) && !$past(o_remote_loopback)
    |-> o_tx_nibble == $past(i_fabric_nibble)) else $error("fabric wrong");
  // loop control may only move right after a write to its register
  AST_LOOP_WR: assert property (
    $changed(o_remote_loopback) |-> $past(wr_lb) || $past(wr_lb, 2))
    else $error("loop changed without write");
  AST_READY_TIME: assert property (
    i_psel && i_penable && !$past(i_penable) |-> ##2 o_pready)
    else $error("pready late");
  AST_READY_QUAL: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access");
  AST_SLVERR_MAP: assert property (o_pready |-> o_pslverr == !(i_paddr
    inside {12'h440, 12'h468, 12'h470, 12'h488, 12'h498, 12'h4a8,
    12'h500, 12'h508, 12'h510})) else $error("slverr wrong");
  AST_PRDATA_HI: assert property (o_pready |-> o_prdata[31:16] == 16'h0000)
    else $error("prdata high half set");
  AST_RST_OUT: assert property (disable iff (1'b0)
    $past(i_sys_rst) |-> o_tx_nibble == '0 && !o_irq && !o_pready)
    else $error("outputs not cleared by reset");
  cover property (o_remote_loopback);
  cover property (o_pready && o_pslverr);
  cover property ($rose(o_irq));
endmodule

bind ppml_regs ppml_regs_checker i_chk (.i_core_clk, .i_sys_rst, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_rx_nibble, .i_fabric_nibble,
  .o_tx_nibble, .o_prdata, .o_pready, .o_pslverr, .o_remote_loopback,
  .o_irq);

// [verif/ppml_regs_bench.sv]
// self-checking bench for ppml_regs over apb
// assumes default parameters and the bound checker
`timescale 1ns/1ps
`define CHK(g, e) chk(33'(g), 33'(e))
module ppml_regs_bench;
  logic clk, rst, psel, pen, pwr, npv, lnk, serr, fend, pready, pslverr;
  logic loop, irq;
  logic [11:0] pa;
  logic [31:0] pwd, prdata;
  ppml_pkg::ppml_np_word_s npw;
  ppml_pkg::ppml_nibble_s rxn, fabn, txn;
  logic [32:0] expq[$];
  logic [31:0] seed = 28970;
  int n_fail = 0;
  int cmp_count = 0;

  ppml_regs i_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_np_valid(npv), .i_np_word(npw), .i_link_up(lnk),
    .i_receive_symbol_error(serr), .i_rx_frame_end(fend),
    .i_rx_nibble(rxn), .i_fabric_nibble(fabn), .o_tx_nibble(txn),
    .o_remote_loopback(loop), .o_irq(irq));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one idle edge first, so back-to-back calls never drive psel twice
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [15:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= {16'h0000, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, pready, 1'b1);
      report_and_stop();
    end
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    expq.push_back({1'b0, 16'h0000, e});
    apb(1'b0, a, 16'h0000);
  endtask

  task automatic frame(input logic e);
    @(posedge clk);
    serr <= e;
    repeat (3) @(posedge clk);
    serr <= 1'b0;
    fend <= 1'b1;
    @(posedge clk);
    fend <= 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    rxn <= 5'(xs());
    fabn <= 5'(xs());
  end

  always @(posedge clk) begin
    if (pready === 1'b1 && pwr === 1'b0) begin
      if (expq.size() == 0) begin
        n_fail++;
        $display("ERROR t=%0t got=%h exp=none", $time, {pslverr, prdata});
      end else begin
        `CHK({pslverr, prdata}, expq.pop_front());
      end
    end
  end

  initial begin
    logic [15:0] w;
    ppml_pkg::ppml_nibble_s r;
    {rst, psel, pen, pwr, npv, lnk, serr, fend} = 8'h80;
    pa = '0;
    pwd = '0;
    npw = '0;
    rxn = '0;
    fabn = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(12'h468, 16'h0000);
    rd(12'h470, 16'h0000);
    rd(12'h488, 16'h00f4);
    rd(12'h4a8, 16'h0000);
    rd(12'h440, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      w = 16'(xs());
      w[15] = i[0];
      w[11] = i[1];
      @(posedge clk);
      npw <= w;
      npv <= 1'b1;
      @(posedge clk);
      npv <= 1'b0;
      wr(12'h440, ~w);
      rd(12'h440, {w[15:12], ~w[11], w[10:0]});
    end
    `CHK(irq, 1'b0);
    rd(12'h500, 16'h0001);
    wr(12'h510, 16'h0001);
    @(posedge clk);
    `CHK(irq, 1'b1);
    wr(12'h508, 16'h0001);
    @(posedge clk);
    `CHK(irq, 1'b0);
    lnk <= 1'b1;
    rd(12'h498, 16'h0001);
    lnk <= 1'b0;
    rd(12'h498, 16'h0000);
    frame(1'b1);
    frame(1'b0);
    frame(1'b1);
    frame(1'b1);
    rd(12'h4a8, 16'h0003);
    rd(12'h4a8, 16'h0000);
    rd(12'h500, 16'h000e);
    `CHK(irq, 1'b0);
    wr(12'h508, 16'h000f);
    rd(12'h500, 16'h0000);
    wr(12'h488, 16'hffff);
    rd(12'h488, 16'hfffe);
    rd(12'h488, 16'hfffc);
    `CHK(loop, 1'b1);
    @(posedge clk);
    r = rxn;
    @(posedge clk);
    `CHK(txn, r);
    wr(12'h488, 16'h00f4);
    rd(12'h488, 16'h00f4);
    `CHK(loop, 1'b0);
    @(posedge clk);
    r = fabn;
    @(posedge clk);
    `CHK(txn, r);
    wr(12'h468, 16'h0005);
    wr(12'h470, 16'h0003);
    rd(12'h470, 16'h0003);
    wr(12'h468, 16'h4005);
    wr(12'h470, 16'haaaa);
    rd(12'h470, 16'haaaa);
    rd(12'h470, 16'haaaa);
    wr(12'h468, 16'h8005);
    rd(12'h470, 16'haaaa);
    wr(12'h470, 16'h1111);
    wr(12'h470, 16'h2222);
    wr(12'h468, 16'h0005);
    rd(12'h470, 16'h0006);
    wr(12'h470, 16'h0004);
    wr(12'h468, 16'hffe5);
    rd(12'h468, 16'hffe5);
    rd(12'h470, 16'h1111);
    wr(12'h470, 16'h3333);
    rd(12'h470, 16'h2222);
    wr(12'h468, 16'h0005);
    rd(12'h470, 16'h0005);
    wr(12'h470, 16'h0004);
    wr(12'h468, 16'h4005);
    rd(12'h470, 16'h3333);
    wr(12'h468, 16'h0006);
    rd(12'h470, 16'h0000);
    // second reset in mid-run must bring the registers back
    wr(12'h488, 16'h0100);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(12'h468, 16'h0000);
    rd(12'h488, 16'h00f4);
    rd(12'h470, 16'h0000);
    `CHK(loop, 1'b0);
    expq.push_back({1'b1, 32'h0});
    apb(1'b0, 12'h4f0, 16'h0000);
    wr(12'h4f0, 16'h1234);
    @(posedge clk);
    if (expq.size() != 0) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, expq.size(), 0);
    end
    report_and_stop();
  end
endmodule
